// ---- gct_pkg.sv ----
// Constants and types shared by the match/capture timer block
package gct_pkg;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 5;
    localparam int NMATCH = 4;
    localparam int NCAP   = 3;
    localparam int STAT_W = NMATCH + NCAP;

    // Word offsets on the register bus
    localparam logic [ADDR_W-1:0] A_CTRL  = 5'h00;
    localparam logic [ADDR_W-1:0] A_COUNT = 5'h01;
    localparam logic [ADDR_W-1:0] A_PRES  = 5'h02;
    localparam logic [ADDR_W-1:0] A_PCNT  = 5'h03;
    localparam logic [ADDR_W-1:0] A_MCTL  = 5'h04;
    localparam logic [ADDR_W-1:0] A_CCTL  = 5'h05;
    localparam logic [ADDR_W-1:0] A_EMR   = 5'h06;
    localparam logic [ADDR_W-1:0] A_PWM   = 5'h07;
    localparam logic [ADDR_W-1:0] A_STAT  = 5'h08;
    localparam logic [ADDR_W-1:0] A_MASK  = 5'h09;
    localparam logic [ADDR_W-1:0] A_MAT0  = 5'h0a;
    localparam logic [ADDR_W-1:0] A_CAP0  = 5'h0e;

    // Control register fields
    localparam int C_EN    = 0;
    localparam int C_CRST  = 1;
    localparam int C_CMODE = 2;
    localparam int C_EDGE  = 3;
    localparam int C_CLR   = 5;
    localparam int CTRL_W  = 7;

    // Match control: one nibble per match; capture control: three bits per channel
    localparam int MC_INT  = 0;
    localparam int MC_RST  = 1;
    localparam int MC_STOP = 2;
    localparam int MC_SH   = 3;
    localparam int MC_STEP = 4;
    localparam int MCTL_W  = 16;
    localparam int CC_RISE = 0;
    localparam int CC_FALL = 1;
    localparam int CC_INT  = 2;
    localparam int CC_STEP = 3;
    localparam int CCTL_W  = 9;
    localparam int EMR_ACT = 4;
    localparam int ACT_W   = 8;

    // Values after reset
    localparam logic [CTRL_W-1:0] CTRL_RST = 7'h00;
    localparam logic [MCTL_W-1:0] MCTL_RST = 16'h0000;
    localparam logic [CCTL_W-1:0] CCTL_RST = 9'h000;
    localparam logic [ACT_W-1:0]  ACT_RST  = 8'h00;
    localparam logic [NMATCH-1:0] MAT_RST  = 4'h0;
    localparam logic [STAT_W-1:0] STAT_RST = 7'h00;
    localparam logic [DATA_W-1:0] CNT_RST  = 32'h0000_0000;

    typedef enum logic [1:0] {
        GCT_ACT_NONE = 2'h0,
        GCT_ACT_LOW  = 2'h1,
        GCT_ACT_HIGH = 2'h2,
        GCT_ACT_TOG  = 2'h3
    } gct_act_t;

    typedef enum logic [1:0] {
        GCT_BUS_IDLE = 2'b01,
        GCT_BUS_ACK  = 2'b10
    } gct_bus_t;
endpackage

// ---- gct_sync.sv ----
// Three-stage pin synchroniser with agreement-qualified edge pulses
`timescale 1ns/1ps
module gct_sync
#(
    parameter int W = 4
)
(
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] rise,
    output logic      [W-1:0] fall
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;
    logic [W-1:0] stab_reg;
    logic [W-1:0] agree;

    // First stage feeds only the second stage
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
        end
        else
        begin
            s1_reg <= din;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // A change counts only once stages two and three agree
    assign agree = ~(s2_reg ^ s3_reg);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            stab_reg <= '0;
        else
            stab_reg <= (stab_reg & ~agree) | (s3_reg & agree);
    end

    assign rise = agree & s3_reg & ~stab_reg;
    assign fall = agree & ~s3_reg & stab_reg;
endmodule

// ---- gct_match.sv ----
// One match channel: shadow and active value with equality compare
`timescale 1ns/1ps
module gct_match
#(
    parameter int W = 32
)
(
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         wr,
    input  wire logic [W-1:0] wdata,
    input  wire logic         shadow_en,
    input  wire logic         reload,
    input  wire logic [W-1:0] count,
    output logic      [W-1:0] value,
    output logic              hit
);
    import gct_pkg::*;

    logic [W-1:0] shad_reg;
    logic [W-1:0] act_reg;

    // Software always lands in the shadow copy
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            shad_reg <= W'(CNT_RST);
        else if (wr)
            shad_reg <= wdata;
    end

    // Active copy moves only at period restart when shadowed, so no runt pulse
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            act_reg <= W'(CNT_RST);
        else if (wr && !shadow_en)
            act_reg <= wdata;
        else if (reload && shadow_en)
            act_reg <= shad_reg;
    end

    assign value = act_reg;
    assign hit   = (count == act_reg);
endmodule

// ---- gct_timer.sv ----
// Match/capture timer-counter with Avalon-MM register slave
//
// Function
// - Counter advances after programmable prescaler divides
// - Counts system clock or external count edges
// - Four match values compared; interrupt or action
// - Three captures snapshot count on input edge
// - Continuous match keeps counter running, optional interrupt
// - Stop match halts counter, optional interrupt
// - Reset match zeroes counter, optional interrupt
// - Shadowed match values avoid PWM output glitches
// - Match outputs go low, high, toggle, or hold
// - Selected capture clears counter and prescaler
// - Match outputs usable as single-edge PWM
`timescale 1ns/1ps
module gct_timer
#(
    parameter int CNT_W = 32
)
(
    input  wire logic                          CLK,
    input  wire logic                          RST_N,
    input  wire logic [gct_pkg::ADDR_W-1:0]    AVS_ADDRESS,
    input  wire logic                          AVS_READ,
    input  wire logic                          AVS_WRITE,
    input  wire logic [gct_pkg::DATA_W-1:0]    AVS_WRITEDATA,
    output logic      [gct_pkg::DATA_W-1:0]    AVS_READDATA,
    output logic                               AVS_WAITREQUEST,
    input  wire logic                          COUNT_IN,
    input  wire logic [gct_pkg::NCAP-1:0]      CAP_IN,
    output logic      [gct_pkg::NMATCH-1:0]    MAT_OUT,
    output logic                               IRQ
);
    import gct_pkg::*;

    if (CNT_W < 2 || CNT_W > DATA_W)
    begin : g_bad_width
        $error("CNT_W must lie between 2 and DATA_W");
    end

    gct_bus_t            bus_st_reg;
    logic [DATA_W-1:0]   rdata_reg;
    logic [DATA_W-1:0]   rd_next;
    logic [CTRL_W-1:0]   ctrl_reg;
    logic [MCTL_W-1:0]   mctl_reg;
    logic [CCTL_W-1:0]   cctl_reg;
    logic [ACT_W-1:0]    act_reg;
    logic [NMATCH-1:0]   mat_reg;
    logic [NMATCH-1:0]   pwm_reg;
    logic [STAT_W-1:0]   status_reg;
    logic [STAT_W-1:0]   mask_reg;
    logic [STAT_W-1:0]   stat_clr;
    logic                irq_reg;
    logic [CNT_W-1:0]    pr_reg;
    logic [CNT_W-1:0]    pc_reg;
    logic [CNT_W-1:0]    tc_reg;
    logic [CNT_W-1:0]    cap_reg [NCAP];
    logic [CNT_W-1:0]    mat_val [NMATCH];
    logic                wr_go;
    logic                in_mat;
    logic                in_cap;
    logic [ADDR_W-1:0]   off_mat;
    logic [ADDR_W-1:0]   off_cap;
    logic [NMATCH-1:0]   mat_wr;
    logic [NMATCH-1:0]   hit;
    logic [NMATCH-1:0]   ev;
    logic [NMATCH-1:0]   mr_int;
    logic [NMATCH-1:0]   mr_rst;
    logic [NMATCH-1:0]   mr_stop;
    logic [NMATCH-1:0]   mr_sh;
    logic [NCAP-1:0]     cc_rise;
    logic [NCAP-1:0]     cc_fall;
    logic [NCAP-1:0]     cc_int;
    logic [NCAP:0]       pin_rise;
    logic [NCAP:0]       pin_fall;
    logic [NCAP-1:0]     cap_ev;
    logic [1:0]          clrsel;
    logic                crst;
    logic                run;
    logic                ext_ev;
    logic                src;
    logic                pc_hit;
    logic                tick;
    logic                rst_ev;
    logic                stop_ev;
    logic                reload;
    logic                capclr;

    // A register write commits only in the cycle waitrequest is low
    assign wr_go = (bus_st_reg == GCT_BUS_ACK) && AVS_WRITE;

    function automatic logic wsel(input logic [ADDR_W-1:0] a);
        wsel = wr_go && (AVS_ADDRESS == a);
    endfunction

    // Address windows for the match and capture banks
    assign off_mat = AVS_ADDRESS - A_MAT0;
    assign off_cap = AVS_ADDRESS - A_CAP0;
    assign in_mat  = (AVS_ADDRESS >= A_MAT0) && (off_mat < ADDR_W'(NMATCH));
    assign in_cap  = (AVS_ADDRESS >= A_CAP0) && (off_cap < ADDR_W'(NCAP));
    assign mat_wr  = (wr_go && in_mat) ? (4'h1 << off_mat[1:0]) : 4'h0;

    // Unpack per-channel control bits
    always_comb
    begin
        for (int i = 0; i < NMATCH; i++)
        begin
            mr_int[i]  = mctl_reg[MC_STEP*i+MC_INT];
            mr_rst[i]  = mctl_reg[MC_STEP*i+MC_RST];
            mr_stop[i] = mctl_reg[MC_STEP*i+MC_STOP];
            mr_sh[i]   = mctl_reg[MC_STEP*i+MC_SH];
        end
        for (int j = 0; j < NCAP; j++)
        begin
            cc_rise[j] = cctl_reg[CC_STEP*j+CC_RISE];
            cc_fall[j] = cctl_reg[CC_STEP*j+CC_FALL];
            cc_int[j]  = cctl_reg[CC_STEP*j+CC_INT];
        end
    end

    // Pins are asynchronous; bit 0 is the count input, the rest captures
    gct_sync #(.W(NCAP + 1)) u_sync
    (
        .clk   (CLK),
        .rst_n (RST_N),
        .din   ({CAP_IN, COUNT_IN}),
        .rise  (pin_rise),
        .fall  (pin_fall)
    );

    // Count edge select: 0 rising, 1 falling, 2 or 3 both
    assign crst   = ctrl_reg[C_CRST];
    assign clrsel = ctrl_reg[C_CLR+:2];
    assign ext_ev = (pin_rise[0] & (ctrl_reg[C_EDGE+:2] != 2'h1))
                  | (pin_fall[0] & (ctrl_reg[C_EDGE+:2] != 2'h0));
    assign src    = ctrl_reg[C_CMODE] ? ext_ev : 1'b1;
    assign run    = ctrl_reg[C_EN] & ~crst;
    assign pc_hit = (pc_reg == pr_reg);
    assign tick   = run & src & pc_hit;
    assign ev     = {NMATCH{tick}} & hit;
    assign rst_ev = |(ev & mr_rst);
    assign stop_ev = |(ev & mr_stop);
    assign reload = rst_ev;
    assign cap_ev = (pin_rise[NCAP:1] & cc_rise) | (pin_fall[NCAP:1] & cc_fall);
    assign capclr = (clrsel != 2'h0) && cap_ev[clrsel - 2'h1];

    // Match channels; shadow and active copies live in the leaf
    for (genvar i = 0; i < NMATCH; i++)
    begin : g_mat
        gct_match #(.W(CNT_W)) u_match
        (
            .clk       (CLK),
            .rst_n     (RST_N),
            .wr        (mat_wr[i]),
            .wdata     (AVS_WRITEDATA[CNT_W-1:0]),
            .shadow_en (mr_sh[i]),
            .reload    (reload),
            .count     (tc_reg),
            .value     (mat_val[i]),
            .hit       (hit[i])
        );
    end

    // Bus handshake: one wait cycle, then a single-cycle acknowledge
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
            bus_st_reg <= GCT_BUS_IDLE;
        else
        begin
            case (bus_st_reg)
                GCT_BUS_IDLE:
                    if (AVS_READ || AVS_WRITE)
                        bus_st_reg <= GCT_BUS_ACK;
                GCT_BUS_ACK:
                    bus_st_reg <= GCT_BUS_IDLE;
                default:
                    bus_st_reg <= GCT_BUS_IDLE;
            endcase
        end
    end

    // Read mux; unmapped words read as zero
    always_comb
    begin
        rd_next = '0;
        case (AVS_ADDRESS)
            A_CTRL:  rd_next = DATA_W'(ctrl_reg);
            A_COUNT: rd_next = DATA_W'(tc_reg);
            A_PRES:  rd_next = DATA_W'(pr_reg);
            A_PCNT:  rd_next = DATA_W'(pc_reg);
            A_MCTL:  rd_next = DATA_W'(mctl_reg);
            A_CCTL:  rd_next = DATA_W'(cctl_reg);
            A_EMR:   rd_next = DATA_W'({act_reg, mat_reg});
            A_PWM:   rd_next = DATA_W'(pwm_reg);
            A_STAT:  rd_next = DATA_W'(status_reg);
            A_MASK:  rd_next = DATA_W'(mask_reg);
            default:
            begin
                if (in_mat)
                    rd_next = DATA_W'(mat_val[off_mat[1:0]]);
                else if (in_cap)
                    rd_next = DATA_W'(cap_reg[off_cap[1:0]]);
            end
        endcase
    end

    // Read data sampled on entry to the acknowledge cycle
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
            rdata_reg <= '0;
        else if (bus_st_reg == GCT_BUS_IDLE && AVS_READ)
            rdata_reg <= rd_next;
    end

    // Control; a stop match overrides a same-cycle enable write
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
            ctrl_reg <= CTRL_RST;
        else
        begin
            if (wsel(A_CTRL))
                ctrl_reg <= AVS_WRITEDATA[CTRL_W-1:0];
            if (stop_ev)
                ctrl_reg[C_EN] <= 1'b0;
        end
    end

    // Plain configuration registers
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            mctl_reg <= MCTL_RST;
            cctl_reg <= CCTL_RST;
            pwm_reg  <= MAT_RST;
            mask_reg <= STAT_RST;
            pr_reg   <= CNT_W'(CNT_RST);
        end
        else
        begin
            if (wsel(A_MCTL))
                mctl_reg <= AVS_WRITEDATA[MCTL_W-1:0];
            if (wsel(A_CCTL))
                cctl_reg <= AVS_WRITEDATA[CCTL_W-1:0];
            if (wsel(A_PWM))
                pwm_reg <= AVS_WRITEDATA[NMATCH-1:0];
            if (wsel(A_MASK))
                mask_reg <= AVS_WRITEDATA[STAT_W-1:0];
            if (wsel(A_PRES))
                pr_reg <= AVS_WRITEDATA[CNT_W-1:0];
        end
    end

    // Prescaler counts counting-clock events and wraps at the limit
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
            pc_reg <= CNT_W'(CNT_RST);
        else if (crst || capclr)
            pc_reg <= '0;
        else if (wsel(A_PCNT))
            pc_reg <= AVS_WRITEDATA[CNT_W-1:0];
        else if (run && src)
            pc_reg <= pc_hit ? '0 : pc_reg + 1'b1;
    end

    // Main counter; a reset match lands on zero instead of match + 1
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
            tc_reg <= CNT_W'(CNT_RST);
        else if (crst || capclr)
            tc_reg <= '0;
        else if (wsel(A_COUNT))
            tc_reg <= AVS_WRITEDATA[CNT_W-1:0];
        else if (rst_ev)
            tc_reg <= '0;
        else if (tick && !stop_ev)
            tc_reg <= tc_reg + 1'b1;
    end

    // Capture snapshots take the count before any same-cycle clear
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            for (int j = 0; j < NCAP; j++)
                cap_reg[j] <= CNT_W'(CNT_RST);
        end
        else
        begin
            for (int j = 0; j < NCAP; j++)
                if (cap_ev[j])
                    cap_reg[j] <= tc_reg;
        end
    end

    // Match outputs; PWM mode rises on match and falls at period restart
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            act_reg <= ACT_RST;
            mat_reg <= MAT_RST;
        end
        else
        begin
            if (wsel(A_EMR))
            begin
                act_reg <= AVS_WRITEDATA[EMR_ACT+:ACT_W];
                mat_reg <= AVS_WRITEDATA[NMATCH-1:0];
            end
            for (int i = 0; i < NMATCH; i++)
            begin
                if (pwm_reg[i])
                begin
                    if (reload)
                        mat_reg[i] <= 1'b0;
                    else if (ev[i])
                        mat_reg[i] <= 1'b1;
                end
                else if (ev[i])
                begin
                    case (gct_act_t'(act_reg[2*i+:2]))
                        GCT_ACT_LOW:  mat_reg[i] <= 1'b0;
                        GCT_ACT_HIGH: mat_reg[i] <= 1'b1;
                        GCT_ACT_TOG:  mat_reg[i] <= ~mat_reg[i];
                        default:      mat_reg[i] <= mat_reg[i];
                    endcase
                end
            end
        end
    end

    // Sticky flags; a new event beats a same-cycle write-one clear
    assign stat_clr = wsel(A_STAT) ? AVS_WRITEDATA[STAT_W-1:0] : '0;

    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
            status_reg <= STAT_RST;
        else
            status_reg <= (status_reg & ~stat_clr)
                        | {cap_ev & cc_int, ev & mr_int};
    end

    // Interrupt lags the flags by one cycle to keep the pin registered
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
            irq_reg <= 1'b0;
        else
            irq_reg <= |(status_reg & mask_reg);
    end

    assign AVS_READDATA    = rdata_reg;
    assign AVS_WAITREQUEST = bus_st_reg[0];
    assign MAT_OUT         = mat_reg;
    assign IRQ             = irq_reg;

    // Checks on the counting core
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_N);

    presc_wrap_a: assert property (tick |=> pc_reg == '0)
        else $error("prescaler did not wrap on tick");
    count_adv_a: assert property (
        (tick && !crst && !capclr && !wsel(A_COUNT) && !rst_ev && !stop_ev)
        |=> tc_reg == $past(tc_reg) + 1'b1)
        else $error("counter did not advance on tick");
    cont_match_a: assert property (
        (tick && hit[1] && !rst_ev && !stop_ev && !capclr && !wsel(A_COUNT)
         && !wsel(A_CTRL)) |=> ctrl_reg[C_EN] && tc_reg == $past(tc_reg) + 1'b1)
        else $error("continuous match disturbed the counter");
    stop_match_a: assert property (
        (stop_ev && !rst_ev && !capclr && !wsel(A_COUNT))
        |=> !ctrl_reg[C_EN] && $stable(tc_reg))
        else $error("stop match did not halt counting");
    reset_match_a: assert property (
        (rst_ev && !wsel(A_COUNT)) |=> tc_reg == '0)
        else $error("reset match did not zero the counter");
    match_flag_a: assert property ((ev[0] && mr_int[0]) |=> status_reg[0] ##1 irq_reg == mask_reg[0])
        else $error("match flag or interrupt wrong");
    cap_snap_a: assert property (cap_ev[0] |=> cap_reg[0] == $past(tc_reg))
        else $error("capture missed the count");
    cap_clear_a: assert property (capclr |=> tc_reg == '0 && pc_reg == '0)
        else $error("capture clear failed");
    out_toggle_a: assert property (
        (ev[3] && !pwm_reg[3] && act_reg[7:6] == GCT_ACT_TOG && !wsel(A_EMR))
        |=> mat_reg[3] != $past(mat_reg[3]))
        else $error("match output did not toggle");
    pwm_rise_a: assert property ((ev[1] && pwm_reg[1] && !reload) |=> mat_reg[1])
        else $error("pwm output did not rise on match");
    shadow_hold_a: assert property ((mr_sh[0] && !reload) |=> $stable(mat_val[0]))
        else $error("shadowed match changed mid period");
    ext_count_a: assert property (
        (ctrl_reg[C_CMODE] && !ext_ev && !crst && !capclr && !wsel(A_PCNT))
        |=> $stable(pc_reg))
        else $error("prescaler moved without a count edge");

    cov_period_c: cover property (tick && rst_ev && |(pwm_reg & mat_reg));
    cov_capclr_c: cover property (capclr);
    cov_stop_c:   cover property (stop_ev);
    cov_bus_c:    cover property (wr_go && in_mat);
endmodule

// ---- gct_pins.sv ----
// Pin-side model: external count source and capture inputs
`timescale 1ns/1ps
module gct_pins
(
    input  wire logic                     clk,
    output logic                          cnt,
    output logic      [gct_pkg::NCAP-1:0] cap
);
    import gct_pkg::*;

    initial
    begin
        cnt = 1'b0;
        cap = '0;
    end

    // Each level held four cycles so the three-stage synchroniser sees it
    task automatic pulse(input int ch, input int n);
        repeat (n)
        begin
            if (ch < 0)
                cnt <= 1'b1;
            else
                cap[ch] <= 1'b1;
            repeat (4) @(posedge clk);
            if (ch < 0)
                cnt <= 1'b0;
            else
                cap[ch] <= 1'b0;
            repeat (4) @(posedge clk);
        end
    endtask
endmodule

// ---- gct_timer_bench.sv ----
// Self-checking bench for the match/capture timer
`timescale 1ns/1ps
module gct_timer_bench;
    import gct_pkg::*;
    logic              clk = 1'b0;
    logic              rst_n = 1'b0;
    logic [ADDR_W-1:0] adr = '0;
    logic              av_rd = 1'b0;
    logic              av_wr = 1'b0;
    logic [DATA_W-1:0] wd = '0;
    logic [DATA_W-1:0] rdat;
    logic              wait_rq;
    logic              cnt_in;
    logic [NCAP-1:0]   cap;
    logic [NMATCH-1:0] mat;
    logic              irq;
    logic [DATA_W-1:0] expq[$];
    int                n_mismatch = 0;
    int                cmp_count = 0;
    int                seed = 32'h57d5f4b2;
    int                hi;
    logic [3:0]        lv;

    gct_timer u_gct_timer (.CLK(clk), .RST_N(rst_n), .AVS_ADDRESS(adr),
        .AVS_READ(av_rd), .AVS_WRITE(av_wr), .AVS_WRITEDATA(wd),
        .AVS_READDATA(rdat), .AVS_WAITREQUEST(wait_rq), .COUNT_IN(cnt_in),
        .CAP_IN(cap), .MAT_OUT(mat), .IRQ(irq));
    gct_pins u_gct_pins (.clk(clk), .cnt(cnt_in), .cap(cap));

    initial
        forever #4 clk = ~clk;

    task automatic results();
        if (n_mismatch == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Holds the request until waitrequest is seen low, then releases
    task automatic bus(input logic w, input int a, input logic [DATA_W-1:0] d);
        int k;
        k = 0;
        adr <= ADDR_W'(a);
        wd <= d;
        av_wr <= w;
        av_rd <= !w;
        do
        begin
            @(posedge clk);
            k++;
            if (k > 20)
            begin
                n_mismatch++;
                results();
            end
        end while (wait_rq !== 1'b0);
        av_rd <= 1'b0;
        av_wr <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wreg(input int a, input logic [DATA_W-1:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rreg(input int a, input logic [DATA_W-1:0] e);
        expq.push_back(e);
        bus(1'b0, a, '0);
    endtask

    // Read data taken at the completing edge, against the oldest note
    always @(posedge clk)
        if (av_rd && wait_rq === 1'b0)
            chk(rdat, expq.pop_front());

    initial
    begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rreg(A_COUNT, 0);
        rreg(5'h1f, 0);
        // Timer mode: continuous match at 10, stop match at 20
        wreg(A_MAT0, 20);
        wreg(A_MAT0 + 1, 10);
        wreg(A_MCTL, 16'h0015);
        wreg(A_MASK, 3);
        wreg(A_CTRL, 1);
        repeat (40) @(posedge clk);
        rreg(A_COUNT, 20);
        rreg(A_CTRL, 0);
        rreg(A_STAT, 3);
        chk(32'(irq), 1);
        wreg(A_STAT, 3);
        rreg(A_STAT, 0);
        chk(32'(irq), 0);
        // External count through a prescaler limit of two
        wreg(A_MCTL, 0);
        wreg(A_PRES, 2);
        wreg(A_COUNT, 0);
        wreg(A_CTRL, 5);
        u_gct_pins.pulse(-1, 7);
        rreg(A_COUNT, 2);
        rreg(A_PCNT, 1);
        // Capture on channel 0 rising, clearing counter and prescaler
        wreg(A_PRES, 0);
        wreg(A_CCTL, 9'h005);
        wreg(A_MASK, 7'h10);
        wreg(A_CTRL, 7'h25);
        u_gct_pins.pulse(0, 1);
        rreg(A_CAP0, 2);
        rreg(A_COUNT, 0);
        rreg(A_PCNT, 0);
        chk(32'(irq), 1);
        wreg(A_STAT, 7'h7f);
        // One match event drives each output with a different action
        wreg(A_CCTL, 0);
        wreg(A_MCTL, 16'h1111);
        wreg(A_CTRL, 5);
        lv = 4'($random(seed));
        for (int i = 0; i < NMATCH; i++)
            wreg(A_MAT0 + i, 5);
        wreg(A_EMR, {24'he4, lv});
        wreg(A_COUNT, 5);
        u_gct_pins.pulse(-1, 1);
        chk(32'(mat), {28'h0, ~lv[3], 1'b1, 1'b0, lv[0]});
        rreg(A_COUNT, 6);
        rreg(A_STAT, 32'h0f);
        // Shadowed value loads only on the reset-match tick
        wreg(A_MCTL, 16'h000a);
        wreg(A_MAT0, 8);
        rreg(A_MAT0, 5);
        wreg(A_COUNT, 5);
        u_gct_pins.pulse(-1, 1);
        rreg(A_MAT0, 8);
        rreg(A_COUNT, 0);
        // PWM: period of five ticks, output 1 high from its match at 2
        wreg(A_MCTL, 16'h0002);
        wreg(A_MAT0, 4);
        wreg(A_MAT0 + 1, 2);
        wreg(A_PWM, 4'h2);
        wreg(A_CTRL, 1);
        repeat (20) @(posedge clk);
        hi = 0;
        repeat (10)
        begin
            @(posedge clk);
            hi += int'(mat[1] === 1'b1);
        end
        chk(32'(hi), 4);
        results();
    end
endmodule
